// file: timer2_pkg.sv
package timer2_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_FLAGS = 8'h37;
  localparam logic [7:0] ADDR_ASYNC = 8'hB6;
  localparam logic [7:0] ADDR_CTL_A = 8'hB0;
  localparam logic [7:0] ADDR_CTL_B = 8'hB1;
  localparam logic [7:0] ADDR_COUNT = 8'hB2;
  localparam logic [7:0] ADDR_CMP_A = 8'hB3;
  localparam logic [7:0] ADDR_CMP_B = 8'hB4;
  localparam logic [7:0] ADDR_MASK = 8'h70;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_FLAGS = 3'h0;
  localparam logic [4:0] RESET_BUSY = 5'h00;
  localparam logic [1:0] RESET_PAIR = 2'h0;

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  localparam logic [7:0] CTL_A_RD_MASK = 8'hF3;
  localparam logic [7:0] CTL_B_RD_MASK = 8'h0F;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int WAVE_HIGH_BIT = 3;
  localparam int EXT_CLK_BIT = 6;
  localparam int ASYNC_SEL_BIT = 5;
  localparam int FLAG_W = 3;
  localparam int BUSY_W = 5;

  // Indices of the five holding/live register pairs and of their busy bits
  localparam int IDX_CTL_B = 0;
  localparam int IDX_CTL_A = 1;
  localparam int IDX_CMP_B = 2;
  localparam int IDX_CMP_A = 3;
  localparam int IDX_COUNT = 4;

  // ****************************************************************
  // Modes and encodings
  // ****************************************************************
  localparam logic [2:0] WAVE_FAST_TOP_A = 3'h7;
  localparam logic [1:0] WAVE_PC_LOW = 2'h1;
  localparam logic [1:0] WAVE_FAST_LOW = 2'h3;

  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_CLEAR = 2'h2;
  localparam logic [1:0] OUT_SET = 2'h3;

  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  localparam logic [2:0] PRESCALE_STOP = 3'h0;
  localparam logic [9:0] PRESCALE_ONE = 10'h001;
  // Low prescaler bits that must all be one for a tick, per select code
  localparam logic [7:0][9:0] PRESCALE_MASK = {
    10'h3FF, 10'h0FF, 10'h07F, 10'h03F, 10'h01F, 10'h007, 10'h000, 10'h000
  };

endpackage : timer2_pkg

// file: async_timer2.sv
// Overview of operation
// RULE_01: Writing force-compare-B one applies a match to wave output B per its output mode.
// RULE_02: Force strobes act only in non-PWM modes; software writes zero otherwise.
// RULE_03: A forced compare sets no flag and never clears the counter.
// RULE_04: Force-compare-B always reads back as zero.
// RULE_05: Control register B bits five and four read as zero.
// RULE_06: Clock select: stop, undivided, then divide by 8,32,64,128,256,1024.
// RULE_07: The counter register reads and writes the live 8-bit count.
// RULE_08: A counter write blocks compare match on the next timer tick.
// RULE_09: Compare register A is compared continuously; match drives flag and output A.
// RULE_10: Compare register B is compared continuously; match drives flag and output B.
// RULE_11: External clock buffer enabled when both bits set; oscillator runs otherwise. Code: oscillator runs only with async select set.
// RULE_12: Async select picks I/O clock when zero, slow oscillator pin when one.
// RULE_13: Software rewrites all five timer registers after changing async select.
// RULE_14: Async counter write sets counter busy until loaded from holding register.
// RULE_15: Async compare writes set their own busy until transferred.
// RULE_16: Async control writes set their own busy until transferred.
// RULE_17: Software never writes an async register while its busy flag is set.
// RULE_18: Counter reads live value; compare and control reads return holding registers.
// RULE_19: Each enable with the global bit lets its flag request an interrupt.
// RULE_20: Compare-B flag sets on match with compare B; requests with enable and global.
// RULE_21: Compare-B flag clears on vector execution or by writing one.
// RULE_22: Compare-A flag sets on match with compare A; same clearing.
// RULE_23: Overflow flag sets on overflow, or at bottom reversal in phase correct PWM.
// RULE_24: Waveform mode combines control B high bit with control A low bits.
// RULE_25: Prescaler source follows async select; writes cross through holding registers.
module async_timer2 (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic slowOscPin,
  input wire logic globalIrqEn,
  input wire logic [2:0] vectorAck,
  output logic waveOutA,
  output logic waveOutB,
  output logic [2:0] irqReq,
  output logic extClockInputEn,
  output logic oscRunning
);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic [3:0] wrPair;
  logic wrCount;
  logic wrFlags;
  logic wrAsync;
  logic wrMask;
  assign wrPair[timer2_pkg::IDX_CTL_B] = regWr && (regAddr == timer2_pkg::ADDR_CTL_B);
  assign wrPair[timer2_pkg::IDX_CTL_A] = regWr && (regAddr == timer2_pkg::ADDR_CTL_A);
  assign wrPair[timer2_pkg::IDX_CMP_B] = regWr && (regAddr == timer2_pkg::ADDR_CMP_B);
  assign wrPair[timer2_pkg::IDX_CMP_A] = regWr && (regAddr == timer2_pkg::ADDR_CMP_A);
  assign wrCount = regWr && (regAddr == timer2_pkg::ADDR_COUNT);
  assign wrFlags = regWr && (regAddr == timer2_pkg::ADDR_FLAGS);
  assign wrAsync = regWr && (regAddr == timer2_pkg::ADDR_ASYNC);
  assign wrMask = regWr && (regAddr == timer2_pkg::ADDR_MASK);

  // ****************************************************************
  // Clock source selection
  // ****************************************************************
  logic extClk_reg;
  logic asyncSel_reg;
  logic slowSync1_reg;
  logic slowSync2_reg;
  logic slowSync3_reg;
  logic slowLevel_reg;
  logic slowRise;
  logic srcTick;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      extClk_reg <= 1'b0;
      asyncSel_reg <= 1'b0;
    end else if (wrAsync) begin
      extClk_reg <= regWrData[timer2_pkg::EXT_CLK_BIT];
      asyncSel_reg <= regWrData[timer2_pkg::ASYNC_SEL_BIT];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      slowSync1_reg <= 1'b0;
      slowSync2_reg <= 1'b0;
      slowSync3_reg <= 1'b0;
      slowLevel_reg <= 1'b0;
    end else begin
      slowSync1_reg <= slowOscPin;
      slowSync2_reg <= slowSync1_reg;
      slowSync3_reg <= slowSync2_reg;
      if (slowSync2_reg == slowSync3_reg) begin
        slowLevel_reg <= slowSync3_reg;
      end
    end
  end
  assign slowRise = (slowSync2_reg == slowSync3_reg) && slowSync3_reg && !slowLevel_reg;
  assign srcTick = asyncSel_reg ? slowRise : 1'b1; // RULE_12 RULE_25
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      extClockInputEn <= 1'b0;
      oscRunning <= 1'b0;
    end else begin
      extClockInputEn <= extClk_reg && asyncSel_reg; // RULE_11
      oscRunning <= asyncSel_reg && !extClk_reg; // RULE_11
    end
  end

  // ****************************************************************
  // Holding and live registers
  // ****************************************************************
  logic [7:0] hold_reg [4];
  logic [7:0] live_reg [4];
  logic [7:0] countHold_reg;
  logic [timer2_pkg::BUSY_W-1:0] busy_reg;
  logic [7:0] ctlA;
  logic [7:0] ctlB;
  logic [7:0] cmpA;
  logic [7:0] cmpB;
  for (genvar i = 0; i < 4; i++) begin : g_pair
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        hold_reg[i] <= timer2_pkg::RESET_BYTE;
        live_reg[i] <= timer2_pkg::RESET_BYTE;
      end else begin
        if (wrPair[i]) begin
          hold_reg[i] <= regWrData;
        end
        if (wrPair[i] && !asyncSel_reg) begin
          live_reg[i] <= regWrData;
        end else if (busy_reg[i] && srcTick) begin
          live_reg[i] <= hold_reg[i]; // RULE_15 RULE_16 RULE_25
        end
      end
    end
  end
  assign ctlA = live_reg[timer2_pkg::IDX_CTL_A];
  assign ctlB = live_reg[timer2_pkg::IDX_CTL_B];
  assign cmpA = live_reg[timer2_pkg::IDX_CMP_A];
  assign cmpB = live_reg[timer2_pkg::IDX_CMP_B];
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      countHold_reg <= timer2_pkg::RESET_BYTE;
    end else if (wrCount) begin
      countHold_reg <= regWrData;
    end
  end
  // A write in the same cycle as a transfer keeps the flag set
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      busy_reg <= timer2_pkg::RESET_BUSY;
    end else begin
      for (int i = 0; i < timer2_pkg::BUSY_W; i++) begin
        if ((i == timer2_pkg::IDX_COUNT ? wrCount : wrPair[i[1:0]]) && asyncSel_reg) begin
          busy_reg[i] <= 1'b1; // RULE_14 RULE_15 RULE_16
        end else if (srcTick) begin
          busy_reg[i] <= 1'b0; // RULE_14 RULE_15 RULE_16
        end
      end
    end
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  logic [9:0] prescale_reg;
  logic [2:0] clockSel;
  logic [9:0] prescaleMask;
  logic timerTick;
  assign clockSel = ctlB[2:0];
  assign prescaleMask = timer2_pkg::PRESCALE_MASK[clockSel];
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prescale_reg <= 10'h000;
    end else if (srcTick) begin
      prescale_reg <= prescale_reg + timer2_pkg::PRESCALE_ONE;
    end
  end
  assign timerTick = srcTick && (clockSel != timer2_pkg::PRESCALE_STOP)
    && ((prescale_reg & prescaleMask) == prescaleMask); // RULE_06

  // ****************************************************************
  // Counter
  // ****************************************************************
  logic [2:0] waveMode;
  logic isPhase;
  logic isFast;
  logic [7:0] count_reg;
  logic countDown_reg;
  logic blockMatch_reg;
  logic countLoad;
  logic [7:0] topValue;
  logic atTop;
  logic matchA;
  logic matchB;
  logic overflow;
  assign waveMode = {ctlB[timer2_pkg::WAVE_HIGH_BIT], ctlA[1:0]}; // RULE_24
  assign isPhase = (waveMode[1:0] == timer2_pkg::WAVE_PC_LOW);
  assign isFast = (waveMode[1:0] == timer2_pkg::WAVE_FAST_LOW);
  assign topValue = waveMode[2] || (waveMode[1:0] == 2'h2) ? cmpA : timer2_pkg::COUNT_MAX; // RULE_24
  assign atTop = (count_reg == topValue);
  assign countLoad = (wrCount && !asyncSel_reg) || (busy_reg[timer2_pkg::IDX_COUNT] && srcTick);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count_reg <= timer2_pkg::RESET_BYTE;
      countDown_reg <= 1'b0;
    end else if (wrCount && !asyncSel_reg) begin
      count_reg <= regWrData; // RULE_07
    end else if (busy_reg[timer2_pkg::IDX_COUNT] && srcTick) begin
      count_reg <= countHold_reg; // RULE_14
    end else if (timerTick) begin
      if (isPhase) begin
        if (!countDown_reg && atTop) begin
          countDown_reg <= 1'b1;
          count_reg <= count_reg - timer2_pkg::COUNT_ONE;
        end else if (countDown_reg && count_reg == timer2_pkg::COUNT_BOTTOM) begin
          countDown_reg <= 1'b0;
          count_reg <= count_reg + timer2_pkg::COUNT_ONE;
        end else if (countDown_reg) begin
          count_reg <= count_reg - timer2_pkg::COUNT_ONE;
        end else begin
          count_reg <= count_reg + timer2_pkg::COUNT_ONE;
        end
      end else begin
        countDown_reg <= 1'b0;
        count_reg <= atTop ? timer2_pkg::COUNT_BOTTOM : count_reg + timer2_pkg::COUNT_ONE;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      blockMatch_reg <= 1'b0;
    end else if (countLoad) begin
      blockMatch_reg <= 1'b1; // RULE_08
    end else if (timerTick) begin
      blockMatch_reg <= 1'b0; // RULE_08
    end
  end
  assign matchA = timerTick && !blockMatch_reg && (count_reg == cmpA); // RULE_09 RULE_08
  assign matchB = timerTick && !blockMatch_reg && (count_reg == cmpB); // RULE_10 RULE_08
  assign overflow = timerTick && (isPhase
    ? (countDown_reg && count_reg == timer2_pkg::COUNT_BOTTOM)
    : (waveMode == timer2_pkg::WAVE_FAST_TOP_A ? atTop
      : count_reg == timer2_pkg::COUNT_MAX)); // RULE_23

  // ****************************************************************
  // Force strobes
  // ****************************************************************
  logic [1:0] forcePend_reg;
  logic forceFire;
  logic forceA;
  logic forceB;
  assign forceFire = !busy_reg[timer2_pkg::IDX_CTL_B] || srcTick;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      forcePend_reg <= timer2_pkg::RESET_PAIR;
    end else if (wrPair[timer2_pkg::IDX_CTL_B]) begin
      forcePend_reg <= {regWrData[timer2_pkg::FORCE_A_BIT], regWrData[timer2_pkg::FORCE_B_BIT]};
    end else if (forceFire) begin
      forcePend_reg <= timer2_pkg::RESET_PAIR;
    end
  end
  assign forceA = forcePend_reg[1] && forceFire && !isPhase && !isFast; // RULE_02
  assign forceB = forcePend_reg[0] && forceFire && !isPhase && !isFast; // RULE_01 RULE_02

  // ****************************************************************
  // Waveform outputs
  // ****************************************************************
  function automatic logic waveNext(input logic cur, input logic [1:0] outMode, input logic hit,
    input logic forced, input logic phase, input logic fast, input logic down,
    input logic wrapBottom, input logic toggleOk);
    logic result;
    result = cur;
    if (phase) begin
      if (hit && outMode[1]) begin
        result = outMode[0] ^ down;
      end else if (hit && outMode == timer2_pkg::OUT_TOGGLE && toggleOk) begin
        result = !cur;
      end
    end else if (fast) begin
      if (wrapBottom && outMode[1]) begin
        result = !outMode[0];
      end else if (hit && outMode[1]) begin
        result = outMode[0];
      end else if (hit && outMode == timer2_pkg::OUT_TOGGLE && toggleOk) begin
        result = !cur;
      end
    end else if (hit || forced) begin
      case (outMode)
        timer2_pkg::OUT_TOGGLE: result = !cur;
        timer2_pkg::OUT_CLEAR: result = 1'b0;
        timer2_pkg::OUT_SET: result = 1'b1;
        default: result = cur;
      endcase
    end
    return result;
  endfunction : waveNext
  logic wrapBottom;
  assign wrapBottom = timerTick && atTop;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      waveOutA <= 1'b0;
      waveOutB <= 1'b0;
    end else begin
      waveOutA <= waveNext(waveOutA, ctlA[7:6], matchA, forceA, isPhase, isFast,
        countDown_reg, wrapBottom, waveMode[2]); // RULE_09
      waveOutB <= waveNext(waveOutB, ctlA[5:4], matchB, forceB, isPhase, isFast,
        countDown_reg, wrapBottom, 1'b0); // RULE_01 RULE_10
    end
  end

  // ****************************************************************
  // Flags and interrupt requests
  // ****************************************************************
  logic [timer2_pkg::FLAG_W-1:0] flags_reg;
  logic [timer2_pkg::FLAG_W-1:0] mask_reg;
  logic [timer2_pkg::FLAG_W-1:0] flagSet;
  logic [timer2_pkg::FLAG_W-1:0] flagClear;
  // Forced compares never feed the flags
  assign flagSet = {matchB, matchA, overflow}; // RULE_03 RULE_20 RULE_22 RULE_23
  assign flagClear = vectorAck | (wrFlags ? regWrData[timer2_pkg::FLAG_W-1:0] : 3'h0);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flags_reg <= timer2_pkg::RESET_FLAGS;
    end else begin
      flags_reg <= (flags_reg & ~flagClear) | flagSet; // RULE_21 RULE_22 RULE_23
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mask_reg <= timer2_pkg::RESET_FLAGS;
    end else if (wrMask) begin
      mask_reg <= regWrData[timer2_pkg::FLAG_W-1:0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irqReq <= timer2_pkg::RESET_FLAGS;
    end else begin
      irqReq <= flags_reg & mask_reg & {timer2_pkg::FLAG_W{globalIrqEn}}; // RULE_19 RULE_20
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      regRdData <= timer2_pkg::RESET_BYTE;
    end else if (regRd) begin
      case (regAddr)
        timer2_pkg::ADDR_CTL_A:
          regRdData <= hold_reg[timer2_pkg::IDX_CTL_A] & timer2_pkg::CTL_A_RD_MASK; // RULE_18
        timer2_pkg::ADDR_CTL_B:
          regRdData <= hold_reg[timer2_pkg::IDX_CTL_B] & timer2_pkg::CTL_B_RD_MASK; // RULE_04 RULE_05
        timer2_pkg::ADDR_CMP_A: regRdData <= hold_reg[timer2_pkg::IDX_CMP_A]; // RULE_18
        timer2_pkg::ADDR_CMP_B: regRdData <= hold_reg[timer2_pkg::IDX_CMP_B]; // RULE_18
        timer2_pkg::ADDR_COUNT: regRdData <= count_reg; // RULE_07 RULE_18
        timer2_pkg::ADDR_ASYNC: regRdData <= {1'b0, extClk_reg, asyncSel_reg, busy_reg};
        timer2_pkg::ADDR_FLAGS: regRdData <= {5'h00, flags_reg};
        timer2_pkg::ADDR_MASK: regRdData <= {5'h00, mask_reg};
        default: regRdData <= timer2_pkg::RESET_BYTE;
      endcase
    end else begin
      regRdData <= timer2_pkg::RESET_BYTE;
    end
  end
endmodule : async_timer2

// file: async_timer2_props.sv
module async_timer2_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic slowOscPin,
  input wire logic globalIrqEn,
  input wire logic [2:0] vectorAck,
  input wire logic waveOutA,
  input wire logic waveOutB,
  input wire logic [2:0] irqReq,
  input wire logic extClockInputEn,
  input wire logic oscRunning
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // Bus sequences
  // ****************************************************************
  sequence maskWrRd;
    regWr && regAddr == timer2_pkg::ADDR_MASK ##2 regRd && regAddr == timer2_pkg::ADDR_MASK;
  endsequence
  sequence asyncWr(logic [1:0] sel);
    regWr && regAddr == timer2_pkg::ADDR_ASYNC && regWrData[6:5] == sel;
  endsequence
  sequence readOf(logic [7:0] a);
    regRd && regAddr == a;
  endsequence

  chk_idle_read_zero:
    assert property (!regRd |=> regRdData == 8'h00)
      else $error("read data not zero outside a read answer");
  chk_ctlb_reserved_zero:
    assert property (readOf(timer2_pkg::ADDR_CTL_B) |=> regRdData[7:4] == 4'h0)
      else $error("control B force or reserved bits read nonzero");
  chk_flags_upper_zero:
    assert property (readOf(timer2_pkg::ADDR_FLAGS) |=> regRdData[7:3] == 5'h00)
      else $error("flag register upper bits nonzero");
  chk_async_top_zero:
    assert property (readOf(timer2_pkg::ADDR_ASYNC) |=> !regRdData[7])
      else $error("async status bit 7 nonzero");
  chk_unmapped_zero:
    assert property (regRd && !(regAddr inside {8'h37, 8'hB6, 8'hB0, 8'hB1, 8'hB2, 8'hB3,
      8'hB4, 8'h70}) |=> regRdData == 8'h00)
      else $error("unmapped read returned data");
  chk_mask_readback:
    assert property (maskWrRd |=> regRdData == ($past(regWrData, 3) & 8'h07))
      else $error("interrupt enables read back wrong");
  chk_irq_global_gate:
    assert property (!globalIrqEn |=> irqReq == 3'h0)
      else $error("interrupt request without global enable");
  chk_irq_mask_gate:
    assert property (regWr && regAddr == timer2_pkg::ADDR_MASK && regWrData == 8'h00
      ##1 !regWr |=> irqReq == 3'h0)
      else $error("interrupt request with all enables off");
  chk_clock_exclusive:
    assert property (!(extClockInputEn && oscRunning))
      else $error("oscillator and external buffer both on");
  chk_ext_follows:
    assert property (asyncWr(2'h3) |-> ##[1:2] extClockInputEn && !oscRunning)
      else $error("external clock buffer not enabled");
  chk_osc_follows:
    assert property (asyncWr(2'h1) |-> ##[1:2] oscRunning && !extClockInputEn)
      else $error("oscillator not running in async mode");
endmodule : async_timer2_props

bind async_timer2 async_timer2_props async_timer2_props_inst (.sys_clk(sys_clk), .rstn(rstn),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .slowOscPin(slowOscPin), .globalIrqEn(globalIrqEn),
  .vectorAck(vectorAck), .waveOutA(waveOutA), .waveOutB(waveOutB), .irqReq(irqReq),
  .extClockInputEn(extClockInputEn), .oscRunning(oscRunning));

// file: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rstn, regWr, regRd, slowOscPin, globalIrqEn, waveOutA, waveOutB, waveExp;
  logic extClockInputEn, oscRunning;
  logic [7:0] regAddr, regWrData, regRdData, rdVal, c1, d, bitv;
  logic [2:0] vectorAck, irqReq;
  logic [31:0] lfsrState = 32'h0000A4CE;
  int numErrors = 0;
  int testsRun = 0;
  int span;
  logic [7:0] addrs [8] = '{timer2_pkg::ADDR_FLAGS, timer2_pkg::ADDR_ASYNC,
    timer2_pkg::ADDR_CTL_A, timer2_pkg::ADDR_CTL_B, timer2_pkg::ADDR_COUNT,
    timer2_pkg::ADDR_CMP_A, timer2_pkg::ADDR_CMP_B, timer2_pkg::ADDR_MASK};
  logic [7:0] rm [8] = '{8'h00, 8'h00, timer2_pkg::CTL_A_RD_MASK, timer2_pkg::CTL_B_RD_MASK,
    8'hFF, 8'hFF, 8'hFF, 8'h07};
  logic [7:0] st [3] = '{8'hFC, 8'h3D, 8'h7D};
  logic [1:0] modes [5] = '{2'h2, 2'h3, 2'h1, 2'h2, 2'h1};

  async_timer2 async_timer2_inst (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .slowOscPin(slowOscPin), .globalIrqEn(globalIrqEn), .vectorAck(vectorAck),
    .waveOutA(waveOutA), .waveOutB(waveOutB), .irqReq(irqReq),
    .extClockInputEn(extClockInputEn), .oscRunning(oscRunning));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] rnd();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState[7:0];
  endfunction : rnd

  function automatic int divOf(input logic [2:0] sel);
    int t [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    return t[sel];
  endfunction : divOf

  function automatic logic forceNext(input logic cur, input logic [1:0] mode);
    case (mode)
      2'h0: return cur;
      2'h1: return !cur;
      2'h2: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction : forceNext

  task check(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task checkBit(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: pin got %b expected %b", $time, got, exp);
    end
  endtask : checkBit

  // Strobe for one cycle, then one idle cycle so no signal is set twice in a step
  task wr(input logic [7:0] a, input logic [7:0] v);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
    @(posedge sys_clk);
  endtask : rd

  task rdChk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rdVal);
    check(rdVal, exp);
  endtask : rdChk

  task finishTest();
    $display("checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finishTest

  initial begin
    repeat (60000) @(posedge sys_clk);
    numErrors++;
    finishTest();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rstn = 1'b0; regAddr = 8'h00; regWrData = 8'h00; regWr = 1'b0; regRd = 1'b0;
    slowOscPin = 1'b0; globalIrqEn = 1'b0; vectorAck = 3'h0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    foreach (addrs[i]) rdChk(addrs[i], 8'h00);
    for (int r = 0; r < 3; r++) begin
      for (int i = 2; i < 8; i++) begin
        d = rnd() & ((i == 3) ? 8'h38 : 8'hFF);
        wr(addrs[i], d);
        rdChk(addrs[i], d & rm[i]);
      end
    end
    for (int i = 2; i < 8; i++) wr(addrs[i], 8'h00);
    rdChk(timer2_pkg::ADDR_ASYNC, 8'h00);
    wr(8'h55, 8'hFF);
    rdChk(8'h55, 8'h00);
    for (int s = 0; s < 8; s++) begin
      span = (s == 0) ? 100 : 5 * divOf(s[2:0]);
      wr(timer2_pkg::ADDR_CTL_B, {5'h00, s[2:0]});
      rd(timer2_pkg::ADDR_COUNT, c1);
      repeat (span - 2) @(posedge sys_clk);
      rd(timer2_pkg::ADDR_COUNT, rdVal);
      check(rdVal - c1, (s == 0) ? 8'h00 : 8'h05);
    end
    wr(timer2_pkg::ADDR_CTL_B, 8'h00);
    for (int i = 0; i < 6; i++) begin
      bitv = 8'h01 << (i % 3);
      globalIrqEn <= (i < 3);
      wr(timer2_pkg::ADDR_FLAGS, 8'h07);
      wr(timer2_pkg::ADDR_MASK, bitv);
      wr(timer2_pkg::ADDR_CMP_A, 8'h40);
      wr(timer2_pkg::ADDR_CMP_B, 8'h80);
      wr(timer2_pkg::ADDR_COUNT, st[i % 3]);
      wr(timer2_pkg::ADDR_CTL_B, 8'h01);
      repeat (10) @(posedge sys_clk);
      wr(timer2_pkg::ADDR_CTL_B, 8'h00);
      repeat (3) @(posedge sys_clk);
      rdChk(timer2_pkg::ADDR_FLAGS, bitv);
      check({5'h00, irqReq}, (i < 3) ? bitv : 8'h00);
      if (i < 3) wr(timer2_pkg::ADDR_FLAGS, bitv);
      else begin
        vectorAck <= bitv[2:0];
        @(posedge sys_clk);
        vectorAck <= 3'h0;
        @(posedge sys_clk);
      end
      rdChk(timer2_pkg::ADDR_FLAGS, 8'h00);
    end
    wr(timer2_pkg::ADDR_CTL_B, 8'h01);
    wr(timer2_pkg::ADDR_COUNT, 8'h80);
    wr(timer2_pkg::ADDR_CTL_B, 8'h00);
    rdChk(timer2_pkg::ADDR_FLAGS, 8'h00);
    waveExp = 1'b0;
    foreach (modes[k]) begin
      wr(timer2_pkg::ADDR_CTL_A, {modes[k], modes[k], 4'h0});
      wr(timer2_pkg::ADDR_CTL_B, 8'hC0);
      repeat (2) @(posedge sys_clk);
      waveExp = forceNext(waveExp, modes[k]);
      checkBit(waveOutB, waveExp);
      checkBit(waveOutA, waveExp);
    end
    wr(timer2_pkg::ADDR_CTL_A, 8'hA3);
    wr(timer2_pkg::ADDR_CTL_B, 8'hC0);
    repeat (2) @(posedge sys_clk);
    checkBit(waveOutB, waveExp);
    checkBit(waveOutA, waveExp);
    wr(timer2_pkg::ADDR_CTL_A, 8'h00);
    rdChk(timer2_pkg::ADDR_CTL_B, 8'h00);
    rdChk(timer2_pkg::ADDR_FLAGS, 8'h00);
    wr(timer2_pkg::ADDR_COUNT, 8'h00);
    wr(timer2_pkg::ADDR_ASYNC, 8'h20);
    repeat (2) @(posedge sys_clk);
    checkBit(oscRunning, 1'b1);
    wr(timer2_pkg::ADDR_CMP_A, 8'h11);
    wr(timer2_pkg::ADDR_CMP_B, 8'h22);
    wr(timer2_pkg::ADDR_CTL_A, 8'h30);
    wr(timer2_pkg::ADDR_CTL_B, 8'h08);
    wr(timer2_pkg::ADDR_COUNT, 8'h5A);
    rdChk(timer2_pkg::ADDR_ASYNC, 8'h3F);
    rdChk(timer2_pkg::ADDR_COUNT, 8'h00);
    rdChk(timer2_pkg::ADDR_CMP_A, 8'h11);
    slowOscPin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    slowOscPin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rdChk(timer2_pkg::ADDR_ASYNC, 8'h20);
    rdChk(timer2_pkg::ADDR_COUNT, 8'h5A);
    rdChk(timer2_pkg::ADDR_CTL_B, 8'h08);
    wr(timer2_pkg::ADDR_ASYNC, 8'h60);
    repeat (2) @(posedge sys_clk);
    checkBit(extClockInputEn, 1'b1);
    checkBit(oscRunning, 1'b0);
    wr(timer2_pkg::ADDR_ASYNC, 8'h40);
    repeat (2) @(posedge sys_clk);
    checkBit(extClockInputEn, 1'b0);
    finishTest();
  end
endmodule : testbench
